// File: pkg/flash_host_pkg.sv
// Constants, register map and types shared by the flash host controller.
package flash_host_pkg;

    // ==========================================================================
    // Clock and bus-cycle timing
    // ==========================================================================
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned CNT_W          = 10;
    localparam int unsigned READ_ACCESS_NS = 100;   // Output valid after chip and output enable.
    localparam int unsigned WRITE_PULSE_NS = 50;    // Write strobe low time.
    localparam int unsigned BUS_GAP_NS     = 30;    // Idle time between two bus cycles.
    localparam int unsigned RESET_BUSY_NS  = 2000;  // Busy may persist this long after reset.

    // Least times round up to whole cycles, and never fall below one cycle.
    function automatic logic [CNT_W-1:0] ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c == 0) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

    localparam logic [CNT_W-1:0] SYNC_CYCLES = 10'h002;
    localparam logic [CNT_W-1:0] READ_LAST   = ns_to_cycles(READ_ACCESS_NS) + SYNC_CYCLES - 10'h001;
    localparam logic [CNT_W-1:0] WRITE_LAST  = ns_to_cycles(WRITE_PULSE_NS) - 10'h001;
    localparam logic [CNT_W-1:0] GAP_LAST    = ns_to_cycles(BUS_GAP_NS) - 10'h001;
    localparam logic [CNT_W-1:0] HOLD_LAST   = ns_to_cycles(RESET_BUSY_NS) - 10'h001;

    // ==========================================================================
    // Register map of the controller (APB, byte addresses)
    // ==========================================================================
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] ADDR_OFFSET   = 8'h04;
    localparam logic [7:0] WDATA_OFFSET  = 8'h08;
    localparam logic [7:0] RDATA_OFFSET  = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;

    localparam int unsigned CTRL_GO_BIT    = 0;
    localparam int unsigned CTRL_OP_LSB    = 1;
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_DONE_BIT  = 1;
    localparam int unsigned STAT_RES_LSB   = 2;
    localparam int unsigned STAT_RDY_BIT   = 4;
    localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
    localparam logic [15:0] WDATA_RESET    = 16'h0000;

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_POLL, OP_RESET} op_type;
    typedef enum logic [1:0] {RES_OK, RES_TIMEOUT, RES_ABORT} result_type;

    // ==========================================================================
    // Status bits polled on the flash data bus
    // ==========================================================================
    localparam int unsigned POLLING_COMPLEMENT_BIT = 7;
    localparam int unsigned MAIN_TOGGLE_BIT        = 6;
    localparam int unsigned TIMEOUT_FAIL_BIT       = 5;
    localparam int unsigned ERASE_TIMER_BIT        = 3;
    localparam int unsigned SECTOR_TOGGLE_BIT      = 2;
    localparam int unsigned BUFFER_ABORT_BIT       = 1;

    // Fields of the device's operation_status register, read back by software.
    localparam int unsigned OPSTAT_READY_BIT    = 7;
    localparam int unsigned OPSTAT_ESUSP_BIT    = 6;
    localparam int unsigned OPSTAT_ERASE_BIT    = 5;
    localparam int unsigned OPSTAT_PROGRAM_BIT  = 4;
    localparam int unsigned OPSTAT_ABORT_BIT    = 3;
    localparam int unsigned OPSTAT_PSUSP_BIT    = 2;
    localparam int unsigned OPSTAT_PROTECT_BIT  = 1;

endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    // =========================================================================
    // Synchroniser stages
    // =========================================================================
    logic [W-1:0] meta_q;

    // The first stage feeds only the second, so metastability cannot spread.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule // pin_sync

`default_nettype wire

// File: rtl/flash_host_ctrl.sv
// Host-side controller driving a parallel NOR flash bus and polling its status.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Host sends reset after timeout; busy may last 2 us afterwards.
// - Buffer abort bit at one; host sends the abort reset sequence.
// - Host reads status at an address belonging to the operation.
// - Host reads toggle twice, and rechecks once timeout bit becomes one.
// - Host clears failure by reset or register clear; ready returns high.

module flash_host_ctrl #(
    parameter int unsigned ADDR_W = 24,
    parameter int unsigned DQ_W   = 16
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic      [ADDR_W-1:0] flash_addr_o,
    output logic                   flash_ce_n_o,
    output logic                   flash_oe_n_o,
    output logic                   flash_we_n_o,
    output logic      [DQ_W-1:0]   flash_dq_o,
    output logic                   flash_dq_oe_n_o,
    input  wire logic [DQ_W-1:0]   flash_dq_i,
    input  wire logic              flash_ready_busy_i
);

    // =========================================================================
    // Reset release and pin synchronisation
    // =========================================================================
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP, ST_EVAL, ST_HOLDOFF} state_type;

    logic [1:0]                       rst_sync_q;
    logic                             rst_n;
    logic [DQ_W:0]                    pin_q;
    logic [DQ_W-1:0]                  dq_sync;
    logic                             rdy_sync;
    state_type                        state_q;
    logic [flash_host_pkg::CNT_W-1:0] cnt_q;
    flash_host_pkg::op_type           op_q;
    flash_host_pkg::result_type       result_q;
    logic [ADDR_W-1:0]                addr_q;
    logic [DQ_W-1:0]                  wdata_q;
    logic [DQ_W-1:0]                  rdata_q;
    logic [DQ_W-1:0]                  prev_q;
    logic                             have_prev_q;
    logic                             recheck_q;
    logic                             busy_q;
    logic                             fin_q;
    logic                             done_q;
    logic [31:0]                      rd_word;
    logic                             wr_en;
    logic                             go;
    logic                             toggle_same;
    logic [1:0]                       op_field;

    // Release is synchronous so no flip-flop leaves reset on a ragged edge.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    pin_sync #(
        .W (DQ_W + 1)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .d_i       ({flash_ready_busy_i, flash_dq_i}),
        .q_o       (pin_q)
    );
    assign dq_sync  = pin_q[DQ_W-1:0];
    assign rdy_sync = pin_q[DQ_W];

    // =========================================================================
    // APB slave
    // =========================================================================
    function automatic logic reg_hit(input logic [7:0] a);
        return (a == flash_host_pkg::CTRL_OFFSET)  || (a == flash_host_pkg::ADDR_OFFSET) ||
               (a == flash_host_pkg::WDATA_OFFSET) || (a == flash_host_pkg::RDATA_OFFSET) ||
               (a == flash_host_pkg::STATUS_OFFSET);
    endfunction

    assign wr_en = psel_i && penable_i && pready_o && pwrite_i && reg_hit(paddr_i);
    assign go    = wr_en && (paddr_i == flash_host_pkg::CTRL_OFFSET) &&
                   pwdata_i[flash_host_pkg::CTRL_GO_BIT] && !busy_q;
    assign op_field = pwdata_i[flash_host_pkg::CTRL_OP_LSB +: 2];

    // Read data is assembled from the current registers during the setup cycle.
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr_i)
            flash_host_pkg::CTRL_OFFSET:   rd_word[flash_host_pkg::CTRL_OP_LSB +: 2] = op_q;
            flash_host_pkg::ADDR_OFFSET:   rd_word[ADDR_W-1:0] = addr_q;
            flash_host_pkg::WDATA_OFFSET:  rd_word[DQ_W-1:0] = wdata_q;
            flash_host_pkg::RDATA_OFFSET:  rd_word[DQ_W-1:0] = rdata_q;
            flash_host_pkg::STATUS_OFFSET: begin
                rd_word[flash_host_pkg::STAT_BUSY_BIT] = busy_q;
                rd_word[flash_host_pkg::STAT_DONE_BIT] = done_q;
                rd_word[flash_host_pkg::STAT_RES_LSB +: 2] = result_q;
                rd_word[flash_host_pkg::STAT_RDY_BIT] = rdy_sync;
            end
            default:                       rd_word = 32'h0000_0000;
        endcase
    end

    // No wait state: ready rises in the first access cycle of every transfer.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !reg_hit(paddr_i);
            prdata_o  <= (psel_i && !penable_i) ? rd_word : 32'h0000_0000;
        end
    end

    // Address and data are frozen while an operation runs.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_q  <= flash_host_pkg::ADDR_RESET[ADDR_W-1:0];
            wdata_q <= flash_host_pkg::WDATA_RESET[DQ_W-1:0];
        end else if (wr_en && !busy_q) begin
            if (paddr_i == flash_host_pkg::ADDR_OFFSET) begin
                addr_q <= pwdata_i[ADDR_W-1:0];
            end
            if (paddr_i == flash_host_pkg::WDATA_OFFSET) begin
                wdata_q <= pwdata_i[DQ_W-1:0];
            end
        end
    end

    // A finish in the same cycle as a clear wins, so no completion is lost.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= fin_q || (done_q && !(wr_en && (paddr_i == flash_host_pkg::STATUS_OFFSET)
                      && pwdata_i[flash_host_pkg::STAT_DONE_BIT]));
        end
    end

    // =========================================================================
    // Bus-cycle engine and status polling
    // =========================================================================
    assign toggle_same = (prev_q[flash_host_pkg::MAIN_TOGGLE_BIT] ==
                          rdata_q[flash_host_pkg::MAIN_TOGGLE_BIT]);

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= ST_IDLE;
            cnt_q           <= '0;
            op_q            <= flash_host_pkg::OP_READ;
            result_q        <= flash_host_pkg::RES_OK;
            rdata_q         <= '0;
            prev_q          <= '0;
            have_prev_q     <= 1'b0;
            recheck_q       <= 1'b0;
            busy_q          <= 1'b0;
            fin_q           <= 1'b0;
            flash_addr_o    <= '0;
            flash_ce_n_o    <= 1'b1;
            flash_oe_n_o    <= 1'b1;
            flash_we_n_o    <= 1'b1;
            flash_dq_o      <= '0;
            flash_dq_oe_n_o <= 1'b1;
        end else begin
            fin_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        op_q         <= flash_host_pkg::op_type'(op_field);
                        busy_q       <= 1'b1;
                        cnt_q        <= '0;
                        have_prev_q  <= 1'b0;
                        recheck_q    <= 1'b0;
                        flash_addr_o <= addr_q;  // Status reads use the operation address.
                        flash_ce_n_o <= 1'b0;
                        if (op_field == flash_host_pkg::OP_READ ||
                            op_field == flash_host_pkg::OP_POLL) begin
                            state_q      <= ST_READ;
                            flash_oe_n_o <= 1'b0;
                        end else begin
                            // Reset and abort-reset commands go out as plain writes.
                            state_q         <= ST_WRITE;
                            flash_we_n_o    <= 1'b0;
                            flash_dq_o      <= wdata_q;
                            flash_dq_oe_n_o <= 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    if (cnt_q == flash_host_pkg::READ_LAST) begin
                        rdata_q      <= dq_sync;
                        flash_ce_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        cnt_q        <= '0;
                        state_q      <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                ST_WRITE: begin
                    if (cnt_q == flash_host_pkg::WRITE_LAST) begin
                        flash_ce_n_o <= 1'b1;
                        flash_we_n_o <= 1'b1;
                        cnt_q        <= '0;
                        state_q      <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                ST_GAP: begin
                    // Data stays driven through the gap to give the device hold time.
                    if (cnt_q == flash_host_pkg::GAP_LAST) begin
                        flash_dq_oe_n_o <= 1'b1;
                        cnt_q           <= '0;
                        unique case (op_q)
                            flash_host_pkg::OP_POLL:  state_q <= ST_EVAL;
                            flash_host_pkg::OP_RESET: state_q <= ST_HOLDOFF;
                            default: begin
                                busy_q   <= 1'b0;
                                fin_q    <= 1'b1;
                                result_q <= flash_host_pkg::RES_OK;
                                state_q  <= ST_IDLE;
                            end
                        endcase
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                ST_EVAL: begin
                    prev_q      <= rdata_q;
                    have_prev_q <= 1'b1;
                    if (have_prev_q && toggle_same) begin
                        busy_q   <= 1'b0;  // Toggling stopped, operation complete.
                        fin_q    <= 1'b1;
                        result_q <= flash_host_pkg::RES_OK;
                        state_q  <= ST_IDLE;
                    end else if (have_prev_q && recheck_q) begin
                        busy_q   <= 1'b0;  // Still toggling after timeout seen.
                        fin_q    <= 1'b1;
                        result_q <= flash_host_pkg::RES_TIMEOUT;
                        state_q  <= ST_IDLE;
                    end else if (have_prev_q && rdata_q[flash_host_pkg::BUFFER_ABORT_BIT]) begin
                        busy_q   <= 1'b0;  // Buffered write aborted.
                        fin_q    <= 1'b1;
                        result_q <= flash_host_pkg::RES_ABORT;
                        state_q  <= ST_IDLE;
                    end else begin
                        // Toggling may stop just as the timeout bit rises, so read once more.
                        if (have_prev_q && rdata_q[flash_host_pkg::TIMEOUT_FAIL_BIT]) begin
                            recheck_q <= 1'b1;
                        end
                        flash_ce_n_o <= 1'b0;
                        flash_oe_n_o <= 1'b0;
                        state_q      <= ST_READ;
                    end
                end
                ST_HOLDOFF: begin
                    // Busy may linger after a reset command, so wait out the window.
                    if (cnt_q == flash_host_pkg::HOLD_LAST) begin
                        busy_q   <= 1'b0;
                        fin_q    <= 1'b1;
                        result_q <= flash_host_pkg::RES_OK;
                        state_q  <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
            endcase
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    strobe_excl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !(!flash_oe_n_o && !flash_we_n_o)) else $error("Read and write strobes both low.");

    read_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !flash_oe_n_o |-> flash_dq_oe_n_o) else $error("Data bus driven during a read.");

    apb_ready_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (psel_i && !penable_i) |=> pready_o) else $error("APB ready missing in access phase.");

    read_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(flash_oe_n_o) |-> ($past(cnt_q) == flash_host_pkg::READ_LAST))
        else $error("Read strobe width wrong.");

    read_gap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(flash_oe_n_o) |-> flash_oe_n_o[*7]) else $error("Reads not separated.");

    holdoff_stay_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state_q == ST_HOLDOFF && cnt_q != flash_host_pkg::HOLD_LAST)
        |=> (state_q == ST_HOLDOFF && busy_q))
        else $error("Reset holdoff ended early.");

    holdoff_end_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state_q == ST_HOLDOFF && cnt_q == flash_host_pkg::HOLD_LAST) |=> (!busy_q ##1 done_q))
        else $error("Reset holdoff did not finish.");

    timeout_res_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state_q == ST_EVAL && have_prev_q && !toggle_same && recheck_q)
        |=> (result_q == flash_host_pkg::RES_TIMEOUT && !busy_q))
        else $error("Timeout not reported.");

    abort_res_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state_q == ST_EVAL && have_prev_q && !toggle_same && !recheck_q &&
         rdata_q[flash_host_pkg::BUFFER_ABORT_BIT])
        |=> (result_q == flash_host_pkg::RES_ABORT)) else $error("Abort not reported.");

    done_ok_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state_q == ST_EVAL && have_prev_q && toggle_same)
        |=> (result_q == flash_host_pkg::RES_OK ##1 done_q))
        else $error("Completion not reported.");

endmodule // flash_host_ctrl

`default_nettype wire

// File: sim/flash_dev_model.sv
// Behavioural flash device that answers status polls and captures writes.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [15:0] din_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [7:0]  toggles_i,
    output logic      [15:0] dq_o,
    output logic             ready_o,
    output logic      [15:0] last_w_o,
    output logic      [23:0] last_a_o
);
    logic [7:0] cnt_q = 8'hFF;
    logic       tog_q = 1'b0;
    logic       busy;
    logic       tfail;
    // Strobes are merged so the order in which chip enable and a strobe settle never matters.
    wire logic  rd_n = ce_n_i | oe_n_i;
    wire logic  wr_n = ce_n_i | we_n_i;
    // Error modes stay busy until the bench changes mode; mode 3 fails as toggling ends.
    assign busy    = (mode_i == 2'h1) || (mode_i == 2'h2) || (cnt_q < toggles_i);
    assign tfail   = (mode_i == 2'h1) || (mode_i == 2'h3 && cnt_q + 8'h01 >= toggles_i);
    assign ready_o = !busy;
    initial dq_o = 16'h5A5A;
    // Each read while busy flips the toggle bit and returns the status word.
    // The count moves last, so busy and the fail bit belong to this read alone.
    always @(negedge rd_n) begin
        if (busy) tog_q = !tog_q;
        dq_o = {8'h00, !busy, tog_q, tfail, 2'h1, 1'b0, mode_i == 2'h2, 1'b0};
        cnt_q = cnt_q + 8'h01;
    end
    // A released bus must not keep the last word, so the model inverts it.
    always @(posedge rd_n) dq_o = ~dq_o;
    // A write starts a new algorithm and restarts the read count.
    always @(posedge wr_n) begin
        last_w_o = din_i;
        last_a_o = addr_i;
        cnt_q = 8'h00;
    end
endmodule // flash_dev_model
`default_nettype wire

// File: sim/test_flash_op_status_and_error_reporting.sv
// Self-checking bench for the flash host controller against a device model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module test_flash_op_status_and_error_reporting;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready, err, ce_n, oe_n, we_n, dq_oe_n, rdy;
    logic [7:0]  paddr, tog;
    logic [1:0]  mode;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] faddr, last_a;
    logic [15:0] dq_out, dq_dev, last_w;
    logic        rd_err;
    int          bad_count = 0;
    int          total_checks = 0;
    logic [31:0] exp_st [4] = '{32'h12, 32'h06, 32'h0A, 32'h12};
    logic [7:0]  tog_tb [4] = '{8'h05, 8'h00, 8'h00, 8'h02};
    wire  logic [15:0] dq_pin = dq_oe_n ? dq_dev : dq_out;
    flash_host_ctrl u_flash_host_ctrl (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(err), .flash_addr_o(faddr),
        .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_o(dq_out),
        .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_pin), .flash_ready_busy_i(rdy));
    flash_dev_model u_flash_dev_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .din_i(dq_out), .addr_i(faddr), .mode_i(mode), .toggles_i(tog), .dq_o(dq_dev),
        .ready_o(rdy), .last_w_o(last_w), .last_a_o(last_a));
    always #2.5 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One APB transfer; ready, read data and error are all taken at the same rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin bad_count++; summarize(); end
        rd = prdata;
        rd_err = err;
        {psel, penable} <= 2'b00;
    endtask
    // Starts one flash operation and polls busy under a bound.
    task automatic run(input flash_host_pkg::op_type op);
        int n;
        apb(1'b1, flash_host_pkg::CTRL_OFFSET, {29'h0, op, 1'b1});
        n = 0;
        do begin
            apb(1'b0, flash_host_pkg::STATUS_OFFSET, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin bad_count++; summarize(); end
        // Done rises a cycle after busy falls, so status is read once more.
        apb(1'b0, flash_host_pkg::STATUS_OFFSET, 32'h0);
    endtask
    initial begin
        {ref_clk, rst_n, psel, penable, pwrite, paddr, pwdata, mode, tog} = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, flash_host_pkg::STATUS_OFFSET, 32'h0);
        `CHK("status_reset", 32'h0000_0010, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, rd_err)
        $display("registers done");
        apb(1'b1, flash_host_pkg::WDATA_OFFSET, 32'h0000_A5C3);
        apb(1'b1, flash_host_pkg::ADDR_OFFSET, 32'h0012_3456);
        run(flash_host_pkg::OP_WRITE);
        `CHK("write_word", 16'hA5C3, last_w)
        `CHK("write_addr", 24'h123456, last_a)
        run(flash_host_pkg::OP_READ);
        apb(1'b0, flash_host_pkg::RDATA_OFFSET, 32'h0);
        `CHK("read_word", 32'h0000_0088, rd & 32'h0000_FFBF)
        $display("write and read done");
        // Completion, timeout, abort, and toggling that stops as the fail bit rises.
        for (int i = 0; i < 4; i++) begin
            mode <= i[1:0];
            tog <= tog_tb[i];
            run(flash_host_pkg::OP_WRITE);
            run(flash_host_pkg::OP_POLL);
            `CHK("poll_status", exp_st[i], rd)
            $display("poll mode %0d done", i);
        end
        mode <= 2'h0;
        tog <= 8'h00;
        run(flash_host_pkg::OP_RESET);
        `CHK("reset_status", 32'h0000_0012, rd)
        $display("reset done");
        summarize();
    end
endmodule // test_flash_op_status_and_error_reporting
`default_nettype wire
